//--- serial_master.sv
// Purpose: two-wire serial bus master with its APB register file
// Assumes: open-drain scl and sda, one clock clk at 250 MHz
// Notes: no clock stretching; bus must be idle high before a frame starts
//
// Our own choices: the register offsets and the APB slave port.

`timescale 1ns/1ps

module serial_master
	import serial_master_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic irq
);

	typedef struct packed {
		logic [6:0] sadr;
		logic rd;
		logic [1:0] iasz;
		logic [23:0] int_addr;
		logic [7:0] low_div;
		logic [7:0] high_div;
		logic [2:0] scale_exp;
		logic [7:0] thr;
		logic [7:0] rhr;
		logic [7:0] shreg;
		logic [8:0] flags;
		logic [8:0] mask;
		logic enabled;
		logic pend;
		logic stop_req;
		logic nak_pend;
		logic need_rs;
		link_state_t state;
		logic [1:0] step;
		logic [17:0] cnt;
		logic [3:0] bitn;
		logic [1:0] part;
		logic [1:0] iacnt;
		logic scl_drv;
		logic sda_drv;
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic scl_f;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		logic sda_f;
		logic [31:0] rdata;
	} core_t;

	core_t s;
	core_t n;
	logic wr_acc;
	logic rd_acc;
	logic setup_rd;
	logic hit;
	logic tick;
	logic rxd;
	logic go_stop;
	logic [17:0] tl;
	logic [17:0] th;
	logic [8:0] fset;
	logic [8:0] fclr;
	logic [7:0] nb;
	logic [31:0] rmux;

	function automatic logic [17:0] period(input logic [7:0] div, input logic [2:0] ex);
		return ({10'h000, div} << ex) + PERIOD_EXTRA;
	endfunction

	// ------------------------------------------------------------
	// bus slave decode
	// ------------------------------------------------------------
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign setup_rd = psel && !penable && !pwrite;
	assign hit = (paddr == OFS_CONTROL) || (paddr == OFS_MASTER_MODE)
		|| (paddr == OFS_INTERNAL_ADDRESS) || (paddr == OFS_CLOCK_WAVEFORM)
		|| (paddr == OFS_BUS_STATUS) || (paddr == OFS_IRQ_ENABLE)
		|| (paddr == OFS_IRQ_DISABLE) || (paddr == OFS_IRQ_MASK)
		|| (paddr == OFS_RX_HOLDING) || (paddr == OFS_TX_HOLDING);
	// read data is captured in the setup cycle, so zero wait states suffice
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = s.rdata;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = s.scl_drv;
	assign sda_oe = s.sda_drv;
	assign irq = |(s.flags & s.mask);
	assign tl = period(s.low_div, s.scale_exp);
	assign th = period(s.high_div, s.scale_exp);
	assign tick = (s.cnt == 18'h00000);
	assign rxd = (s.part == 2'd2) && s.rd;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rmux = 32'h0000_0000;
		case (paddr)
			OFS_MASTER_MODE: rmux = {9'h000, s.sadr, 3'h0, s.rd, 2'h0, s.iasz, 8'h00};
			OFS_INTERNAL_ADDRESS: rmux = {8'h00, s.int_addr};
			OFS_CLOCK_WAVEFORM: rmux = {13'h0000, s.scale_exp, s.high_div, s.low_div};
			OFS_BUS_STATUS: rmux = {23'h000000, s.flags};
			OFS_IRQ_MASK: rmux = {23'h000000, s.mask};
			OFS_RX_HOLDING: rmux = {24'h000000, s.rhr};
			OFS_TX_HOLDING: rmux = {24'h000000, s.thr};
			default: rmux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = s;
		fset = 9'h000;
		fclr = 9'h000;
		nb = s.shreg;
		go_stop = 1'b0;
		// three-stage pin filter; a change counts once stages two and three agree
		n.scl_s1 = scl_in;
		n.scl_s2 = s.scl_s1;
		n.scl_s3 = s.scl_s2;
		if (s.scl_s2 == s.scl_s3)
			n.scl_f = s.scl_s2;
		n.sda_s1 = sda_in;
		n.sda_s2 = s.sda_s1;
		n.sda_s3 = s.sda_s2;
		if (s.sda_s2 == s.sda_s3)
			n.sda_f = s.sda_s2;
		if (setup_rd)
			n.rdata = rmux;

		if (!tick)
			n.cnt = s.cnt - 18'h00001;
		unique case (s.state)
			ST_IDLE:
			begin
				n.scl_drv = 1'b0;
				n.sda_drv = 1'b0;
				if (s.pend && s.enabled && s.scl_f && s.sda_f)
				begin
					n.state = ST_START;
					n.step = 2'd0;
					n.cnt = th - 18'h00001;
					n.pend = 1'b0;
					n.part = 2'd0;
					n.iacnt = s.iasz;
					// reads with an internal address go out as write, then restart
					n.need_rs = s.rd && (s.iasz != 2'b00);
					n.shreg = {s.sadr, s.rd && (s.iasz == 2'b00)};
					fclr[FLG_DONE] = 1'b1;
				end
			end
			ST_START:
			begin
				if (tick)
				begin
					unique case (s.step)
						2'd2:
						begin
							n.scl_drv = 1'b0;
							n.step = 2'd0;
							n.cnt = th - 18'h00001;
						end
						2'd0:
						begin
							n.sda_drv = 1'b1;
							n.step = 2'd1;
							n.cnt = th - 18'h00001;
						end
						default:
						begin
							n.state = ST_BIT;
							n.scl_drv = 1'b1;
							n.sda_drv = ~s.shreg[7];
							n.step = 2'd0;
							n.bitn = 4'd0;
							n.cnt = tl - 18'h00001;
						end
					endcase
				end
			end
			ST_BIT:
			begin
				if (tick && (s.step == 2'd0))
				begin
					n.scl_drv = 1'b0;
					n.step = 2'd1;
					n.cnt = th - 18'h00001;
				end
				else if (tick && (s.bitn != 4'd8))
				begin
					n.shreg = {s.shreg[6:0], rxd & s.sda_f};
					n.bitn = s.bitn + 4'd1;
					n.scl_drv = 1'b1;
					n.step = 2'd0;
					n.cnt = tl - 18'h00001;
					n.sda_drv = rxd ? 1'b0 : ~s.shreg[6];
					if (s.bitn == 4'd7)
					begin
						// master acks each byte except the one before a stop
						n.sda_drv = rxd ? ~s.stop_req : 1'b0;
						if (rxd)
						begin
							n.rhr = {s.shreg[6:0], s.sda_f};
							fset[FLG_RX_READY] = 1'b1;
							fset[FLG_OVERRUN] = s.flags[FLG_RX_READY];
						end
					end
				end
				else if (tick)
				begin
					if (rxd)
						go_stop = s.stop_req;
					else if (s.sda_f)
					begin
						n.nak_pend = 1'b1;
						go_stop = 1'b1;
					end
					else if (s.iacnt != 2'd0)
					begin
						// most significant address byte first; the
						// last one sent is int_addr[7:0]
						unique case (s.iacnt)
							2'd3: nb = s.int_addr[23:16];
							2'd2: nb = s.int_addr[15:8];
							default: nb = s.int_addr[7:0];
						endcase
						n.iacnt = s.iacnt - 2'd1;
						n.part = 2'd1;
					end
					else if (s.need_rs)
						n.need_rs = 1'b0;
					else if (s.rd)
						n.part = 2'd2;
					else if (!s.flags[FLG_TX_READY])
					begin
						// a held byte still goes out before a requested stop
						nb = s.thr;
						fset[FLG_TX_READY] = 1'b1;
						n.part = 2'd2;
					end
					else if (s.stop_req)
						go_stop = 1'b1;
					else
					begin
						fset[FLG_UNDERRUN] = 1'b1;
						go_stop = 1'b1;
					end
					n.scl_drv = 1'b1;
					n.step = 2'd0;
					n.bitn = 4'd0;
					n.cnt = tl - 18'h00001;
					if (go_stop)
					begin
						n.state = ST_STOP;
						n.sda_drv = 1'b1;
					end
					else if (s.need_rs && (s.iacnt == 2'd0))
					begin
						// repeated start, now with the read direction
						n.state = ST_START;
						n.step = 2'd2;
						n.sda_drv = 1'b0;
						n.part = 2'd0;
						n.shreg = {s.sadr, 1'b1};
					end
					else
					begin
						n.shreg = nb;
						n.sda_drv = (n.part == 2'd2 && s.rd) ? 1'b0 : ~nb[7];
					end
				end
			end
			ST_STOP:
			begin
				if (tick)
				begin
					unique case (s.step)
						2'd0:
						begin
							n.scl_drv = 1'b0;
							n.step = 2'd1;
							n.cnt = th - 18'h00001;
						end
						2'd1:
						begin
							n.sda_drv = 1'b0;
							n.step = 2'd2;
							n.cnt = th - 18'h00001;
						end
						default:
						begin
							n.state = ST_IDLE;
							n.step = 2'd0;
							n.stop_req = 1'b0;
							n.nak_pend = 1'b0;
							fset[FLG_DONE] = 1'b1;
							fset[FLG_NO_ACK_FLAG] = s.nak_pend;
							fset[FLG_TX_READY] = s.nak_pend;
						end
					endcase
				end
			end
		endcase

		// --------------------------------------------------------
		// register writes and read side effects
		// --------------------------------------------------------
		if (wr_acc)
		begin
			unique case (paddr)
				OFS_CONTROL:
				begin
					if (pwdata[CMD_START])
						n.pend = 1'b1;
					if (pwdata[CMD_STOP])
						n.stop_req = 1'b1;
					if (pwdata[CMD_MASTER_DISABLE])
						n.enabled = 1'b0;
					else if (pwdata[CMD_MASTER_ENABLE])
					begin
						n.enabled = 1'b1;
						fset[FLG_DONE] = 1'b1;
						fset[FLG_TX_READY] = 1'b1;
					end
				end
				OFS_MASTER_MODE:
				begin
					n.iasz = pwdata[MODE_SIZE_LSB +: 2];
					n.rd = pwdata[MODE_READ_BIT];
					n.sadr = pwdata[MODE_SADDR_LSB +: 7];
				end
				OFS_INTERNAL_ADDRESS: n.int_addr = pwdata[23:0];
				OFS_CLOCK_WAVEFORM:
				begin
					n.low_div = pwdata[WAVE_LOW_LSB +: 8];
					n.high_div = pwdata[WAVE_HIGH_LSB +: 8];
					n.scale_exp = pwdata[WAVE_EXP_LSB +: 3];
				end
				OFS_IRQ_ENABLE: n.mask = s.mask | (pwdata[8:0] & FLAG_BITS);
				OFS_IRQ_DISABLE: n.mask = s.mask & ~pwdata[8:0];
				OFS_TX_HOLDING:
				begin
					n.thr = pwdata[7:0];
					fclr[FLG_TX_READY] = 1'b1;
					if (!s.rd)
						n.pend = 1'b1;
				end
				default:
				begin
				end
			endcase
		end
		if (rd_acc && (paddr == OFS_BUS_STATUS))
		begin
			fclr[FLG_NO_ACK_FLAG] = 1'b1;
			fclr[FLG_OVERRUN] = s.flags[FLG_DONE];
			fclr[FLG_UNDERRUN] = s.flags[FLG_DONE];
		end
		if (rd_acc && (paddr == OFS_RX_HOLDING))
			fclr[FLG_RX_READY] = 1'b1;
		// hardware set wins over a clear in the same cycle
		n.flags = (s.flags & ~fclr) | fset;

		if (wr_acc && (paddr == OFS_CONTROL) && pwdata[CMD_SOFT_RESET])
		begin
			n = '0;
			n.state = ST_IDLE;
			n.scl_f = 1'b1;
			n.sda_f = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.state <= ST_IDLE;
			s.flags <= FLAGS_RESET;
			s.mask <= MASK_RESET;
			s.scl_s1 <= 1'b1;
			s.scl_s2 <= 1'b1;
			s.scl_s3 <= 1'b1;
			s.scl_f <= 1'b1;
			s.sda_s1 <= 1'b1;
			s.sda_s2 <= 1'b1;
			s.sda_s3 <= 1'b1;
			s.sda_f <= 1'b1;
		end
		else
			s <= n;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [17:0] low_len;
	logic [17:0] high_len;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			low_len <= 18'h00000;
			high_len <= 18'h00000;
		end
		else
		begin
			low_len <= s.scl_drv ? low_len + 18'h00001 : 18'h00000;
			high_len <= s.scl_drv ? 18'h00000 : high_len + 18'h00001;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_SCL_LOW_LEN: assert property ($fell(s.scl_drv) && s.state == ST_BIT
		|-> low_len == tl)
		else $error("scl low period wrong");
	AST_SCL_HIGH_LEN: assert property ($rose(s.scl_drv) && s.state == ST_BIT
		&& $past(s.state) == ST_BIT |-> high_len == th)
		else $error("scl high period wrong");
	AST_DONE_FRAME: assert property (s.state != ST_IDLE |-> !s.flags[FLG_DONE])
		else $error("transfer complete high inside frame");
	AST_HOLD_WRITE_CLEARS: assert property (wr_acc && paddr == OFS_TX_HOLDING
		&& s.state == ST_IDLE |=> !s.flags[FLG_TX_READY] && s.pend == !$past(s.rd))
		else $error("holding write did not clear transmit ready");
	AST_RX_READ: assert property (rd_acc && paddr == OFS_RX_HOLDING
		&& fset[FLG_RX_READY] == 1'b0 |=> !s.flags[FLG_RX_READY])
		else $error("receive ready not cleared by read");
	AST_OVERRUN_CAUSE: assert property ($rose(s.flags[FLG_OVERRUN])
		|-> $past(s.flags[FLG_RX_READY]))
		else $error("overrun without pending byte");
	AST_UNDERRUN_STOP: assert property ($rose(s.flags[FLG_UNDERRUN])
		|-> s.state == ST_STOP)
		else $error("underrun without stop");
	AST_NO_ACK_FLAG_WITH_DONE: assert property ($rose(s.flags[FLG_NO_ACK_FLAG])
		|-> s.flags[FLG_DONE] && s.flags[FLG_TX_READY] && $past(s.state) == ST_STOP)
		else $error("no-ack flag not raised with transfer complete");
	AST_IER_SETS: assert property (wr_acc && paddr == OFS_IRQ_ENABLE
		|=> (s.mask & $past(pwdata[8:0]) & FLAG_BITS) == ($past(pwdata[8:0]) & FLAG_BITS))
		else $error("enable write did not set mask");
	AST_IDR_CLEARS: assert property (wr_acc && paddr == OFS_IRQ_DISABLE
		|=> (s.mask & $past(pwdata[8:0])) == 9'h000)
		else $error("disable write did not clear mask");

	COV_WRITE_FRAME: cover property ($rose(s.flags[FLG_DONE]) && !s.rd);
	COV_READ_BYTE: cover property ($rose(s.flags[FLG_RX_READY]));
	COV_NO_ACK_FLAG: cover property ($rose(s.flags[FLG_NO_ACK_FLAG]));
	COV_UNDERRUN: cover property ($rose(s.flags[FLG_UNDERRUN]));

endmodule

//--- serial_master_pkg.sv
// Purpose: shared constants and types of the two-wire serial master
// Assumes: 32-bit APB register bus, byte offsets below are byte addresses
// Notes: status, enable, disable and mask registers share one bit layout

package serial_master_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MASTER_MODE = 8'h04;
	localparam logic [7:0] OFS_INTERNAL_ADDRESS = 8'h0C;
	localparam logic [7:0] OFS_CLOCK_WAVEFORM = 8'h10;
	localparam logic [7:0] OFS_BUS_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
	localparam logic [7:0] OFS_IRQ_DISABLE = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
	localparam logic [7:0] OFS_RX_HOLDING = 8'h30;
	localparam logic [7:0] OFS_TX_HOLDING = 8'h34;

	// ------------------------------------------------------------
	// control command bits
	// ------------------------------------------------------------
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_MASTER_ENABLE = 2;
	localparam int CMD_MASTER_DISABLE = 3;
	localparam int CMD_SOFT_RESET = 7;

	// ------------------------------------------------------------
	// master mode fields
	// ------------------------------------------------------------
	localparam int MODE_SIZE_LSB = 8;
	localparam int MODE_READ_BIT = 12;
	localparam int MODE_SADDR_LSB = 16;

	// ------------------------------------------------------------
	// clock waveform fields
	// ------------------------------------------------------------
	localparam int WAVE_LOW_LSB = 0;
	localparam int WAVE_HIGH_LSB = 8;
	localparam int WAVE_EXP_LSB = 16;
	localparam logic [17:0] PERIOD_EXTRA = 18'h00003;

	// ------------------------------------------------------------
	// status flag positions
	// ------------------------------------------------------------
	localparam int FLG_DONE = 0;
	localparam int FLG_RX_READY = 1;
	localparam int FLG_TX_READY = 2;
	localparam int FLG_OVERRUN = 6;
	localparam int FLG_UNDERRUN = 7;
	localparam int FLG_NO_ACK_FLAG = 8;
	localparam logic [8:0] FLAG_BITS = 9'h1C7;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [8:0] FLAGS_RESET = 9'h000;
	localparam logic [8:0] MASK_RESET = 9'h000;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'b0001,
		ST_START = 4'b0010,
		ST_BIT = 4'b0100,
		ST_STOP = 4'b1000
	} link_state_t;

endpackage

//--- serial_slave_model.sv
// Purpose: behavioural two-wire slave facing the serial master
// Assumes: scl and sda are resolved wire levels with pull-ups
// Notes: acks every byte except those after the address byte while no_ack_flag_data is high

`timescale 1ns/1ps

module serial_slave_model
(
	input wire logic scl,
	input wire logic sda,
	input wire logic no_ack_flag_data,
	input wire logic [7:0] rd_byte,
	output logic sda_pull,
	output logic [7:0] got_byte,
	output logic got_flag
);
	logic [7:0] sh;
	logic addr_ph;
	logic rd;
	logic mack;
	int cnt;

	initial
	begin
		sda_pull = 1'b0;
		got_flag = 1'b0;
		got_byte = 8'h00;
		sh = 8'h00;
		addr_ph = 1'b1;
		rd = 1'b0;
		cnt = 0;
	end

	// ------------------------------------------------------------
	// start, repeated start and stop
	// ------------------------------------------------------------
	always @(negedge sda)
		if (scl === 1'b1)
		begin
			cnt = 0;
			addr_ph = 1'b1;
			rd = 1'b0;
		end

	always @(posedge sda)
		if (scl === 1'b1)
		begin
			cnt = 0;
			addr_ph = 1'b1;
			rd = 1'b0;
			sda_pull = 1'b0;
		end

	// ------------------------------------------------------------
	// bit engine
	// ------------------------------------------------------------
	always @(posedge scl)
	begin
		if (cnt < 8 && !(rd && !addr_ph))
			sh = {sh[6:0], sda};
		if (cnt == 8)
			mack = sda;
		cnt = cnt + 1;
	end

	// drive only while scl is low, so no false start or stop is seen
	always @(negedge scl)
	begin
		if (cnt == 8 && !(rd && !addr_ph))
		begin
			got_byte = sh;
			got_flag = !got_flag;
			rd = addr_ph ? sh[0] : rd;
			sda_pull = !(no_ack_flag_data && !addr_ph);
		end
		else if (cnt == 9)
		begin
			cnt = 0;
			if (rd && !addr_ph && mack)
				rd = 1'b0;
			addr_ph = 1'b0;
			sh = rd_byte;
			sda_pull = rd && !rd_byte[7];
		end
		else
			sda_pull = rd && !addr_ph && cnt < 8 && !sh[7 - cnt];
	end
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the two-wire serial master
// Assumes: one 250 MHz clock, open-drain wires with pull-ups
// Notes: expected results queue up and watchers compare them in order

`timescale 1ns/1ps

module testbench
	import serial_master_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scl_oe, sda_oe, irq, pull, got_flag, hi_bad, sda_prev;
	logic scl_o, sda_o;
	logic no_ack_flag_data = 1'b0;
	logic [7:0] rd_byte = 8'h00;
	logic [7:0] got_byte, d, b1, b2;
	logic [6:0] sa;
	logic [23:0] ia;
	logic [31:0] r, r2, cw;
	logic [32:0] exp_q[$];
	logic [7:0] byte_q[$];
	int error_cnt = 0;
	int compares = 0;
	int seed = 32'h20793665;
	int tl, th, lo, hi, ex;
	int lo_run = 0;
	int hi_run = 0;
	wire scl_line = !scl_oe;
	wire sda_line = !(sda_oe || pull);

	always #2 clk = !clk;

	serial_master serial_master_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_line),
		.scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_o), .sda_oe(sda_oe),
		.irq(irq));

	serial_slave_model serial_slave_model_inst (.scl(scl_line), .sda(sda_line),
		.no_ack_flag_data(no_ack_flag_data), .rd_byte(rd_byte), .sda_pull(pull),
		.got_byte(got_byte), .got_flag(got_flag));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic check_reg(input string nm, input logic [32:0] e, input logic [32:0] g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchers
	// ------------------------------------------------------------
	always @(posedge clk)
		if (psel && penable && pready === 1'b1 && !pwrite)
			check_reg("read data", exp_q.pop_front(), {pslverr, prdata});

	always @(got_flag)
		if (rst_n === 1'b1)
			check_byte("slave byte", byte_q.pop_front(), got_byte);

	// high runs holding a start or stop edge are not plain bit times
	always @(posedge clk)
	begin
		if (scl_oe === 1'b1)
		begin
			if (hi_run > 0 && !hi_bad)
				check_reg("scl high", th, hi_run);
			hi_run = 0;
			hi_bad = 1'b0;
			lo_run++;
		end
		else
		begin
			if (lo_run > 0)
				check_reg("scl low", tl, lo_run);
			lo_run = 0;
			hi_run++;
			if (sda_line !== sda_prev)
				hi_bad = 1'b1;
		end
		sda_prev = sda_line;
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wait_irq(input logic lvl);
		int n;
		n = 0;
		while (irq !== lvl && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		check_reg("irq level", {32'h0, lvl}, {32'h0, irq});
	endtask

	task automatic wframe(input logic [1:0] sz, input logic stop, input logic [32:0] st);
		sa = 7'($random(seed));
		ia = 24'($random(seed));
		d = 8'($random(seed));
		apb(1'b1, OFS_MASTER_MODE, {9'h0, sa, 3'h0, 1'b0, 2'h0, sz, 8'h00});
		apb(1'b1, OFS_INTERNAL_ADDRESS, {8'h00, ia});
		byte_q.push_back({sa, 1'b0});
		for (int i = int'(sz) - 1; i >= 0; i--)
			byte_q.push_back(ia[i * 8 +: 8]);
		byte_q.push_back(d);
		apb(1'b1, OFS_TX_HOLDING, {24'h0, d});
		wait_irq(1'b0);
		if (stop)
			apb(1'b1, OFS_CONTROL, 32'h2);
		wait_irq(1'b1);
		rd(OFS_BUS_STATUS, st);
		rd(OFS_BUS_STATUS, 33'h005);
	endtask

	task automatic rframe(input logic [7:0] b);
		rd_byte = b;
		byte_q.push_back({sa, 1'b0});
		byte_q.push_back(ia[15:8]);
		byte_q.push_back(ia[7:0]);
		byte_q.push_back({sa, 1'b1});
		apb(1'b1, OFS_CONTROL, 32'h3);
		wait_irq(1'b0);
		wait_irq(1'b1);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_MASTER_MODE, 33'h0);
		rd(OFS_INTERNAL_ADDRESS, 33'h0);
		rd(OFS_CLOCK_WAVEFORM, 33'h0);
		rd(OFS_BUS_STATUS, 33'h0);
		rd(OFS_IRQ_MASK, 33'h0);
		rd(OFS_RX_HOLDING, 33'h0);
		rd(OFS_IRQ_ENABLE, 33'h0);
		rd(8'h08, {1'b1, 32'h0});
		r = $random(seed);
		r2 = $random(seed);
		apb(1'b1, OFS_IRQ_ENABLE, r);
		rd(OFS_IRQ_MASK, {1'b0, r & {23'h0, FLAG_BITS}});
		apb(1'b1, OFS_IRQ_DISABLE, r2);
		rd(OFS_IRQ_MASK, {1'b0, r & ~r2 & {23'h0, FLAG_BITS}});
		check_reg("irq idle", 33'h0, {32'h0, irq});
		apb(1'b1, OFS_IRQ_DISABLE, 32'h1FF);
		apb(1'b1, OFS_CONTROL, 32'h4);
		rd(OFS_BUS_STATUS, 33'h005);
		apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
		@(posedge clk);
		check_reg("irq enabled", 33'h1, {32'h0, irq});
		r = $random(seed);
		apb(1'b1, OFS_MASTER_MODE, r);
		rd(OFS_MASTER_MODE, {1'b0, r & 32'h007F1300});
		lo = 1 + ($random(seed) & 3);
		hi = 1 + ($random(seed) & 3);
		ex = $random(seed) & 3;
		tl = (lo << ex) + 3;
		th = (hi << ex) + 3;
		cw = (ex << 16) | (hi << 8) | lo;
		apb(1'b1, OFS_CLOCK_WAVEFORM, cw);
		rd(OFS_CLOCK_WAVEFORM, {1'b0, cw});
		for (int sz = 0; sz < 4; sz++)
			wframe(2'(sz), 1'b1, 33'h005);
		wframe(2'h0, 1'b0, 33'h085);
		no_ack_flag_data = 1'b1;
		wframe(2'h0, 1'b0, 33'h105);
		no_ack_flag_data = 1'b0;
		sa = 7'($random(seed));
		ia = 24'($random(seed));
		apb(1'b1, OFS_MASTER_MODE, {9'h0, sa, 3'h0, 1'b1, 2'h0, 2'h2, 8'h00});
		apb(1'b1, OFS_INTERNAL_ADDRESS, {8'h00, ia});
		b1 = 8'($random(seed));
		b2 = 8'($random(seed));
		rframe(b1);
		rframe(b2);
		rd(OFS_BUS_STATUS, 33'h047);
		rd(OFS_BUS_STATUS, 33'h007);
		rd(OFS_RX_HOLDING, {25'h0, b2});
		rd(OFS_BUS_STATUS, 33'h005);
		repeat (2) @(posedge clk);
		check_reg("pending", 33'h0, 33'(exp_q.size() + byte_q.size()));
		check_reg("pin drive level", 33'h0, {31'h0, scl_o, sda_o});
		give_verdict();
	end

	initial
	begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
endmodule
